// *** inc/fifo_ctrl_pkg.sv ***
// Purpose: constants for the FIFO and packet-mode control block
// Assumes: 8-bit register port, single 100 MHz clock
// Notes: register offsets beyond the control register are local choices
package fifo_ctrl_pkg;
   localparam int unsigned ADDR_W = 4;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned PTR_W = 6;
   localparam int unsigned CNT_W = 7;
   localparam int unsigned FIFO_DEPTH = 64;
   localparam logic [ADDR_W-1:0] ADDR_FUNC_CTRL = 4'h0;
   localparam logic [ADDR_W-1:0] ADDR_TX_ALMOST_FULL = 4'h1;
   localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h2;
   localparam logic [ADDR_W-1:0] ADDR_TX_LEVEL = 4'h3;
   localparam logic [ADDR_W-1:0] ADDR_RX_LEVEL = 4'h4;
   localparam logic [ADDR_W-1:0] ADDR_FIFO_DATA = 4'h5;
   localparam int unsigned BIT_MULTI_PKT = 4;
   localparam int unsigned BIT_AUTO_TX = 3;
   localparam int unsigned BIT_LOW_DUTY = 2;
   localparam int unsigned BIT_RX_CLEAR = 1;
   localparam int unsigned BIT_TX_CLEAR = 0;
   localparam logic [DATA_W-1:0] FUNC_CTRL_RST = 8'h00;
   localparam logic [CNT_W-1:0] TX_ALMOST_FULL_RST = 7'h37;
   localparam logic [DATA_W-1:0] READ_ZERO = 8'h00;
   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_RX = 4'h2,
      ST_TX = 4'h4,
      ST_LDC_RX = 4'h8
   } radio_state_e;
endpackage

// *** hw/byte_fifo.sv ***
// Purpose: 64-byte FIFO with synchronous flush
// Assumes: nothing of the caller; pushes when full and pops when empty are ignored
// Notes: flush wins over push and pop in the same cycle
`timescale 1ns/10ps
module byte_fifo
   import fifo_ctrl_pkg::*;
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_sys_rst,
   // Control
   input wire logic i_flush,
   input wire logic i_push,
   input wire logic [DATA_W-1:0] i_wdata,
   input wire logic i_pop,
   // Status and data
   output logic [DATA_W-1:0] o_rdata,
   output logic [CNT_W-1:0] o_level
);
   typedef struct packed {
      logic [PTR_W-1:0] wr_ptr;
      logic [PTR_W-1:0] rd_ptr;
      logic [CNT_W-1:0] level;
   } fifo_s;
   fifo_s st_ff;
   fifo_s nxt_st;
   logic [DATA_W-1:0] mem [FIFO_DEPTH];
   logic do_push;
   logic do_pop;

   assign do_push = i_push && !i_flush && (st_ff.level != CNT_W'(FIFO_DEPTH));
   assign do_pop = i_pop && !i_flush && (st_ff.level != '0);

   always_comb begin
      nxt_st = st_ff;
      if (i_flush) begin
         nxt_st = '0;
      end else begin
         if (do_push) begin
            nxt_st.wr_ptr = st_ff.wr_ptr + PTR_W'(1);
         end
         if (do_pop) begin
            nxt_st.rd_ptr = st_ff.rd_ptr + PTR_W'(1);
         end
         if (do_push && !do_pop) begin
            nxt_st.level = st_ff.level + CNT_W'(1);
         end else if (do_pop && !do_push) begin
            nxt_st.level = st_ff.level - CNT_W'(1);
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // Memory kept out of the reset struct so it maps to RAM
   always_ff @(posedge i_clk) begin
      if (do_push) begin
         mem[st_ff.wr_ptr] <= i_wdata;
      end
   end

   assign o_rdata = mem[st_ff.rd_ptr];
   assign o_level = st_ff.level;
endmodule

// *** hw/fifo_packet_mode_control.sv ***
// Purpose: FIFO and radio function control register with its FIFO/state effects
// Assumes: packet handler, wake-up timer and modulator are outside
// Notes: one clock, synchronous reset, read data valid one cycle after strobe
// Overview of operation
// - In FIFO receive mode with multi-packet set, keep receiving packets, else leave receive after one, except in a low-duty-cycle on-time.
// - With auto-transmit set, enter transmit at the TX almost-full level and leave when TX empties.
// - With low-duty-cycle set, turn the receiver on at a wake-up event in idle until the on-time ends or the bit clears.
// - Writing the RX clear bit 1 then 0 discards all RX FIFO contents.
// - Writing the TX clear bit 1 then 0 discards all TX FIFO contents.
`timescale 1ns/10ps
module fifo_packet_mode_control
   import fifo_ctrl_pkg::*;
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_sys_rst,
   // Register port
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic [DATA_W-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [DATA_W-1:0] o_rdata,
   // Radio control requests
   input wire logic i_rx_cmd,
   input wire logic i_fifo_mode_rx,
   input wire logic i_wake_event,
   input wire logic i_ldc_on_done,
   // Packet handler, receive side
   input wire logic i_rx_byte_valid,
   input wire logic [DATA_W-1:0] i_rx_byte,
   input wire logic i_rx_pkt_done,
   // Modulator, transmit side
   input wire logic i_tx_byte_take,
   output logic [DATA_W-1:0] o_tx_byte,
   output logic o_tx_byte_avail,
   // State
   output logic o_rx_on,
   output logic o_tx_on
);
   // Whole control state in one struct so reset and update stay in step
   typedef struct packed {
      logic [DATA_W-1:0] ctrl;
      logic [CNT_W-1:0] tx_afull;
      radio_state_e state;
      logic [DATA_W-1:0] rdata;
   } ctl_s;
   ctl_s st_ff;
   ctl_s nxt_st;
   // FIFO heads and fill levels
   logic [DATA_W-1:0] tx_q;
   logic [DATA_W-1:0] rx_q;
   logic [CNT_W-1:0] tx_level;
   logic [CNT_W-1:0] rx_level;
   // FIFO strobes
   logic tx_flush;
   logic rx_flush;
   logic tx_push;
   logic tx_pop;
   logic rx_push;
   logic rx_pop;
   // Register access decode
   logic wr_ctrl;
   logic wr_afull;
   logic wr_fifo;
   logic rd_fifo;
   // State decode
   logic in_idle;
   logic in_rx;
   logic in_tx;
   logic in_ldc;
   // Transition conditions
   logic tx_empty;
   logic auto_tx_go;
   logic ldc_go;
   logic rx_stay;
   logic rx_leave;
   logic tx_last;
   logic ldc_leave;

   // Flush held while the bit is 1; contents gone by the 1-then-0 pair
   assign tx_flush = st_ff.ctrl[BIT_TX_CLEAR];
   assign rx_flush = st_ff.ctrl[BIT_RX_CLEAR];

   byte_fifo u_tx_fifo (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_flush(tx_flush),
      .i_push(tx_push),
      .i_wdata(i_wdata),
      .i_pop(tx_pop),
      .o_rdata(tx_q),
      .o_level(tx_level)
   );

   byte_fifo u_rx_fifo (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_flush(rx_flush),
      .i_push(rx_push),
      .i_wdata(i_rx_byte),
      .i_pop(rx_pop),
      .o_rdata(rx_q),
      .o_level(rx_level)
   );

   // Address qualified once, reused by the FIFO strobes and the register file
   assign wr_ctrl = i_wr && (i_addr == ADDR_FUNC_CTRL);
   assign wr_afull = i_wr && (i_addr == ADDR_TX_ALMOST_FULL);
   assign wr_fifo = i_wr && (i_addr == ADDR_FIFO_DATA);
   assign rd_fifo = i_rd && (i_addr == ADDR_FIFO_DATA);

   // One-hot state, so each decode is a single compare
   assign in_idle = (st_ff.state == ST_IDLE);
   assign in_rx = (st_ff.state == ST_RX);
   assign in_tx = (st_ff.state == ST_TX);
   assign in_ldc = (st_ff.state == ST_LDC_RX);

   // Writes into a held TX FIFO are dropped, not queued for later
   assign tx_push = wr_fifo && !tx_flush;
   // Pop on the read edge itself so back-to-back reads see successive bytes
   assign rx_pop = rd_fifo && !rx_flush;
   assign rx_push = i_rx_byte_valid && (in_rx || in_ldc);
   assign tx_pop = i_tx_byte_take && in_tx;

   assign tx_empty = (tx_level == '0);
   // A zero threshold must not start TX on an empty FIFO
   assign auto_tx_go = in_idle && st_ff.ctrl[BIT_AUTO_TX] && (tx_level >= st_ff.tx_afull) && !tx_empty;
   assign ldc_go = in_idle && st_ff.ctrl[BIT_LOW_DUTY] && i_wake_event;
   // Multi-packet only meaningful in FIFO receive mode
   assign rx_stay = i_fifo_mode_rx && st_ff.ctrl[BIT_MULTI_PKT];
   assign rx_leave = in_rx && i_rx_pkt_done && !rx_stay;
   // Leave on the edge that takes the last byte, not a cycle later
   assign tx_last = in_tx && (tx_empty || ((tx_level == CNT_W'(1)) && tx_pop));
   // Stay on for the whole on-time even after a packet
   assign ldc_leave = in_ldc && (i_ldc_on_done || !st_ff.ctrl[BIT_LOW_DUTY]);

   always_comb begin
      nxt_st = st_ff;
      if (wr_ctrl) begin
         nxt_st.ctrl = i_wdata;
      end
      if (wr_afull) begin
         nxt_st.tx_afull = i_wdata[CNT_W-1:0];
      end
      // Unread cycles keep the last word, so rdata stands until the next read
      if (i_rd) begin
         unique case (i_addr)
            ADDR_FUNC_CTRL: begin
               nxt_st.rdata = st_ff.ctrl;
            end
            ADDR_TX_ALMOST_FULL: begin
               nxt_st.rdata = {1'b0, st_ff.tx_afull};
            end
            ADDR_STATUS: begin
               nxt_st.rdata = {4'h0, st_ff.state};
            end
            ADDR_TX_LEVEL: begin
               nxt_st.rdata = {1'b0, tx_level};
            end
            ADDR_RX_LEVEL: begin
               nxt_st.rdata = {1'b0, rx_level};
            end
            ADDR_FIFO_DATA: begin
               nxt_st.rdata = rx_q;
            end
            default: begin
               nxt_st.rdata = READ_ZERO;
            end
         endcase
      end
      unique case (st_ff.state)
         ST_IDLE: begin
            // Auto transmit outranks a receive request, which outranks a wake event
            if (auto_tx_go) begin
               nxt_st.state = ST_TX;
            end else if (i_rx_cmd) begin
               nxt_st.state = ST_RX;
            end else if (ldc_go) begin
               nxt_st.state = ST_LDC_RX;
            end
         end
         ST_RX: begin
            if (rx_leave) begin
               nxt_st.state = ST_IDLE;
            end
         end
         ST_TX: begin
            if (tx_last) begin
               nxt_st.state = ST_IDLE;
            end
         end
         ST_LDC_RX: begin
            if (ldc_leave) begin
               nxt_st.state = ST_IDLE;
            end
         end
         default: begin
            nxt_st.state = ST_IDLE;
         end
      endcase
   end

   // FIFOs empty themselves through their own reset, not through the flush
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         st_ff.ctrl <= FUNC_CTRL_RST;
         st_ff.tx_afull <= TX_ALMOST_FULL_RST;
         st_ff.state <= ST_IDLE;
         st_ff.rdata <= READ_ZERO;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // Handshake outputs decode the registered state
   assign o_rdata = st_ff.rdata;
   assign o_tx_byte = tx_q;
   assign o_tx_byte_avail = in_tx && !tx_empty;
   assign o_rx_on = in_rx || in_ldc;
   assign o_tx_on = in_tx;
endmodule

// *** sim/fifo_ctrl_asserts.sv ***
// Purpose: port checks of the control block
// Assumes: one clock, sync reset
// Notes: ctrl_ff mirrors the control register
`timescale 1ns/10ps
module fifo_ctrl_asserts
   import fifo_ctrl_pkg::*;
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_sys_rst,
   // Register port
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic [DATA_W-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [DATA_W-1:0] o_rdata,
   // Radio side
   input wire logic i_rx_cmd,
   input wire logic i_fifo_mode_rx,
   input wire logic i_wake_event,
   input wire logic i_rx_pkt_done,
   input wire logic o_tx_byte_avail,
   input wire logic o_rx_on,
   input wire logic o_tx_on
);
   logic [DATA_W-1:0] ctrl_ff;
   logic [DATA_W-1:0] old_ff;
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   // Old copy covers the one-cycle lag of the flush
   always_ff @(posedge i_clk) begin
      old_ff <= i_sys_rst ? FUNC_CTRL_RST : ctrl_ff;
      if (i_sys_rst) begin
         ctrl_ff <= FUNC_CTRL_RST;
      end else if (i_wr && i_addr == ADDR_FUNC_CTRL) begin
         ctrl_ff <= i_wdata;
      end
   end
   tx_hold_a: assert property (ctrl_ff[0] && old_ff[0] |-> !o_tx_byte_avail) else $error("tx fifo not empty");
   rx_flush_a: assert property (i_rd && i_addr == ADDR_RX_LEVEL && ctrl_ff[1] && old_ff[1]
      |=> o_rdata == READ_ZERO) else $error("rx fifo not empty");
   tx_start_a: assert property ($rose(o_tx_on) |-> old_ff[3]) else $error("tx without auto");
   tx_stop_a: assert property (o_tx_on && !o_tx_byte_avail |-> ##[0:2] !o_tx_on) else $error("tx kept on");
   rx_single_a: assert property (o_rx_on && i_rx_pkt_done && !ctrl_ff[2] && !(i_fifo_mode_rx && ctrl_ff[4])
      |=> !o_rx_on) else $error("rx kept on");
   rx_multi_a: assert property (o_rx_on && i_rx_pkt_done && !ctrl_ff[2] && i_fifo_mode_rx && ctrl_ff[4]
      |=> o_rx_on) else $error("rx left");
   ldc_wake_a: assert property (!o_rx_on && !o_tx_on && i_wake_event && ctrl_ff[2] && !ctrl_ff[3] && !i_wr
      |=> o_rx_on) else $error("no wake rx");
   ldc_off_a: assert property (!o_rx_on && !ctrl_ff[2] && !i_rx_cmd && !i_wr |=> !o_rx_on) else $error("rx rose");
   cover property (o_tx_on);
   cover property (o_rx_on && ctrl_ff[4]);
   cover property ($rose(o_rx_on) && ctrl_ff[2]);
endmodule

// *** sim/tx_taker_model.sv ***
// Purpose: modulator model taking TX bytes
// Assumes: takes only while transmitting
// Notes: random stalls stretch the transfer
`timescale 1ns/10ps
module tx_taker_model (
   // Clock
   input wire logic i_clk,
   // Block side
   input wire logic i_tx_on,
   input wire logic i_avail,
   output logic o_take
);
   initial o_take = 1'b0;
   // Gap after each take lets the head update
   always @(posedge i_clk) begin
      o_take <= i_tx_on && i_avail && !o_take && $urandom_range(1);
   end
endmodule

// *** sim/fifo_packet_mode_control_tb_top.sv ***
// Purpose: self-checking bench of the control block
// Assumes: 100 MHz clock, sync reset
// Notes: reads queue expectations, a monitor compares
`timescale 1ns/10ps
module fifo_packet_mode_control_tb_top import fifo_ctrl_pkg::*; ;
   logic i_clk = 0, i_sys_rst = 1, i_wr = 0, i_rd = 0, i_fifo_mode_rx = 0, vld = 0, rd_d = 0, take;
   logic [ADDR_W-1:0] i_addr = '0;
   logic [DATA_W-1:0] i_wdata = '0, rxb = '0, o_rdata, o_tx_byte, e, te, d;
   logic [3:0] ev = '0;
   logic o_tx_byte_avail, o_rx_on, o_tx_on;
   logic [DATA_W-1:0] exp_q[$], tx_exp[$], rx_exp[$];
   int failures = 0, checks = 0;
   always #5 i_clk = ~i_clk;
   fifo_packet_mode_control u_dut (.i_clk, .i_sys_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
      .i_rx_cmd(ev[0]), .i_fifo_mode_rx, .i_wake_event(ev[2]), .i_ldc_on_done(ev[3]), .i_rx_byte_valid(vld),
      .i_rx_byte(rxb), .i_rx_pkt_done(ev[1]), .i_tx_byte_take(take), .o_tx_byte, .o_tx_byte_avail, .o_rx_on, .o_tx_on);
   tx_taker_model u_mod (.i_clk, .i_tx_on(o_tx_on), .i_avail(o_tx_byte_avail), .o_take(take));
   task automatic stop_test();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge i_clk);
      {i_wr, i_addr, i_wdata} <= {1'b1, a, d};
      @(posedge i_clk);
      i_wr <= 0;
   endtask
   task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] x);
      exp_q.push_back(x);
      @(posedge i_clk);
      {i_rd, i_addr} <= {1'b1, a};
      @(posedge i_clk);
      i_rd <= 0;
   endtask
   task automatic pulse(input logic [3:0] m);
      @(posedge i_clk);
      ev <= m;
      @(posedge i_clk);
      ev <= '0;
   endtask
   task automatic wait_tx(input logic v);
      for (int n = 0; n < 200 && o_tx_on !== v; n++) @(negedge i_clk);
      if (o_tx_on !== v) begin
         failures++;
         $display("BAD t=%0t got %h exp %h", $time, o_tx_on, v);
         stop_test();
      end
   endtask
   always @(posedge i_clk) rd_d <= i_rd;
   task automatic rx_byte();
      @(posedge i_clk);
      d = 8'($urandom);
      rx_exp.push_back(d);
      {vld, rxb} <= {1'b1, d};
      @(posedge i_clk);
      vld <= 0;
   endtask
   // Head byte is compared while the take strobe stands
   always @(negedge i_clk) begin
      if (take && o_tx_on) begin
         checks++;
         if (tx_exp.size() == 0) begin
            failures++;
            $display("BAD t=%0t got %h exp %h", $time, o_tx_byte, 8'h00);
         end else begin
            te = tx_exp.pop_front();
            if (o_tx_byte !== te) begin
               failures++;
               $display("BAD t=%0t got %h exp %h", $time, o_tx_byte, te);
            end
         end
      end
   end
   // Sampled mid-cycle, clear of the update edge
   always @(negedge i_clk) begin
      if (rd_d) begin
         e = exp_q.pop_front();
         checks++;
         if (o_rdata !== e) begin
            failures++;
            $display("BAD t=%0t got %h exp %h", $time, o_rdata, e);
         end
      end
   end
   initial begin
      void'($urandom(32'h295493e9));
      repeat (20) @(posedge i_clk);
      i_sys_rst <= 0;
      rd(ADDR_FUNC_CTRL, FUNC_CTRL_RST);
      rd(ADDR_TX_ALMOST_FULL, 8'(TX_ALMOST_FULL_RST));
      rd(4'hf, READ_ZERO);
      repeat (3) wr(ADDR_FIFO_DATA, 8'($urandom));
      rd(ADDR_TX_LEVEL, 8'h03);
      wr(ADDR_FUNC_CTRL, 8'h01);
      rd(ADDR_TX_LEVEL, 8'h00);
      wr(ADDR_FIFO_DATA, 8'h5a);
      wr(ADDR_FUNC_CTRL, 8'h00);
      rd(ADDR_TX_LEVEL, 8'h00);
      pulse(4'h1);
      repeat (2) rx_byte();
      pulse(4'h2);
      rd(ADDR_STATUS, 8'h01);
      rd(ADDR_RX_LEVEL, 8'h02);
      rd(ADDR_FIFO_DATA, rx_exp.pop_front());
      rd(ADDR_RX_LEVEL, 8'h01);
      wr(ADDR_FUNC_CTRL, 8'h10);
      i_fifo_mode_rx <= 1;
      pulse(4'h1);
      pulse(4'h2);
      rd(ADDR_STATUS, 8'h02);
      rx_byte();
      rd(ADDR_RX_LEVEL, 8'h02);
      i_fifo_mode_rx <= 0;
      pulse(4'h2);
      rd(ADDR_STATUS, 8'h01);
      rd(ADDR_FIFO_DATA, rx_exp.pop_front());
      wr(ADDR_FUNC_CTRL, 8'h02);
      rd(ADDR_RX_LEVEL, 8'h00);
      wr(ADDR_FUNC_CTRL, 8'h00);
      rd(ADDR_RX_LEVEL, 8'h00);
      wr(ADDR_FUNC_CTRL, 8'h04);
      pulse(4'h4);
      rd(ADDR_STATUS, 8'h08);
      pulse(4'h8);
      rd(ADDR_STATUS, 8'h01);
      wr(ADDR_TX_ALMOST_FULL, 8'h02);
      wr(ADDR_FUNC_CTRL, 8'h08);
      repeat (2) begin
         d = 8'($urandom);
         tx_exp.push_back(d);
         wr(ADDR_FIFO_DATA, d);
      end
      wait_tx(1);
      wait_tx(0);
      rd(ADDR_TX_LEVEL, 8'h00);
      rd(ADDR_STATUS, 8'h01);
      repeat (3) @(posedge i_clk);
      checks++;
      if (tx_exp.size() != 0) begin
         failures++;
         $display("BAD t=%0t got %h exp %h", $time, tx_exp.size(), 0);
      end
      stop_test();
   end
endmodule
bind fifo_packet_mode_control fifo_ctrl_asserts u_chk (.i_clk, .i_sys_rst, .i_addr, .i_wdata, .i_wr, .i_rd,
   .o_rdata, .i_rx_cmd, .i_fifo_mode_rx, .i_wake_event, .i_rx_pkt_done, .o_tx_byte_avail, .o_rx_on, .o_tx_on);
